/* File: rtl/framer_pkg.sv */
// Shared constants, types and coding tables of the serializer input and control channel
package framer_pkg;
  // Timing base
  localparam int CLK_KHZ = 40000;
  localparam int REV_START_US = 2000;
  localparam int LINK_CHANGE_US = 350;
  localparam int BYPASS_WAIT_US = 1000;
  localparam int REV_START_CYC = REV_START_US * CLK_KHZ / 1000;
  localparam int LINK_CHANGE_CYC = LINK_CHANGE_US * CLK_KHZ / 1000;
  localparam int BYPASS_WAIT_CYC = BYPASS_WAIT_US * CLK_KHZ / 1000;
  // Control-channel bit rate limits: 1 Mbps and 9.6 kbps
  localparam int BAUD_MIN_CYC = CLK_KHZ / 1000;
  localparam int BAUD_MAX_CYC = CLK_KHZ * 10 / 96;
  localparam int BAUD_W = 14;
  localparam int IDLE_SHIFT = 4;
  localparam int UART_LAST_BIT = 9;
  localparam logic [7:0] SYNC_BYTE = 8'h79;
  localparam logic [7:0] ACK_BYTE = 8'hC3;
  localparam logic [7:0] SER_ADDR_DEF = 8'h80;
  localparam logic [7:0] DES_ADDR_DEF = 8'h90;
  localparam int REG_CNT = 2;
  localparam int REG_SELF = 0;
  localparam int REG_PEER = 1;
  // Parallel input and serial word layout
  localparam int PIX_W = 16;
  localparam int NARROW_W = 11;
  localparam int WIDE_W = 15;
  localparam int DATA24_W = 22;
  localparam int DATA32_W = 30;
  localparam int FCC24 = 22;
  localparam int PAR24 = 23;
  localparam int FCC32 = 30;
  localparam int PAR32 = 31;
  localparam int WORD_W = 32;
  localparam int SYM_W = 10;
  localparam int SYM_CNT = 4;
  localparam logic [15:0] SCR_SEED = 16'hFFFF;
  // Pixel clock range check
  localparam int RATE_WIN_CYC = 1024;
  localparam int PDIV_W = 4;
  localparam int PDIV_EDGE_PIX = 8;
  // Index {low_rate, double, wide}: {min kHz, max kHz}; low rate with double is unusable
  localparam int RANGE_KHZ [8][2] = '{'{16660, 50000}, '{12500, 35000}, '{33300, 100000},
    '{25000, 75000}, '{8330, 16660}, '{6250, 12500}, '{1, 0}, '{1, 0}};
  // 8b/10b tables, running disparity negative, abcdei and fghj
  localparam logic [5:0] ENC6 [32] = '{6'b100111, 6'b011101, 6'b101101, 6'b110001,
    6'b110101, 6'b101001, 6'b011001, 6'b111000, 6'b111001, 6'b100101, 6'b010101,
    6'b110100, 6'b001101, 6'b101100, 6'b011100, 6'b010111, 6'b011011, 6'b100011,
    6'b010011, 6'b110010, 6'b001011, 6'b101010, 6'b011010, 6'b111010, 6'b110011,
    6'b100110, 6'b010110, 6'b110110, 6'b001110, 6'b101110, 6'b011110, 6'b101011};
  localparam logic [3:0] ENC4 [8] = '{4'b1011, 4'b1001, 4'b0101, 4'b1100, 4'b1101,
    4'b1010, 4'b0110, 4'b1110};
  localparam logic [5:0] ENC6_FLIP = 6'b111000;
  localparam logic [3:0] ENC4_FLIP = 4'b1100;
  typedef logic [WORD_W-1:0] word_t;
  // Pins sampled on the control clock
  typedef struct packed {
    logic rx;
    logic rev;
    logic mode;
    logic ser_en;
    logic far;
    logic double_input_select;
    logic wide;
    logic low;
    logic ptog;
  } pins_s;
  // Levels sampled on the pixel clock
  typedef struct packed {
    logic double_input_select;
    logic wide;
    logic fcc;
  } pix_cfg_s;
  typedef enum {R_IDLE, R_BAUD, R_BITS, R_STOP} rx_state_e;
  typedef enum {P_ADDR, P_REG, P_CNT, P_DATA} pkt_state_e;
endpackage

/* File: rtl/serializer_input_and_control_channel.sv */
// Pixel capture, serial word framing and control-channel handling of a link serializer
// Summary of operation
// - Single mode latches one word every pixel clock
// - Double mode latches first then second word
// - Double mode sends both words as one
// - Scramble each word, then 8b/10b encode it
// - Control-channel bit follows 22 or 30 data
// - Last bit is parity of preceding bits
// - Reverse channel usable only 2ms after power-up
// - Link start or stop mutes reverse 350us
// - Low rate narrows pixel clock range; no double
// - Mode select picks half- or full-duplex channel
// - Own address defaults 0x80, peer 0x90
// - Base mode detects 9.6kbps to 1Mbps rate
// - Packets open with 0x79, answered with 0xC3
// - Register writes apply after acknowledge is sent
// - Sync byte locks the receive sampling rate
// - Command-only select drops the register byte
// - Bypass ignores commands, blocks registers, passes data
// - Bypass starts after 1ms when host is remote
`timescale 1ns/1ps
`default_nettype none
module serializer_input_and_control_channel
  import framer_pkg::*;
#(
  parameter int REV_START_CYC_P = REV_START_CYC,
  parameter int LINK_CHANGE_CYC_P = LINK_CHANGE_CYC,
  parameter int BYPASS_WAIT_CYC_P = BYPASS_WAIT_CYC
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic pixel_clock_in_i,
  input wire logic [PIX_W-1:0] first_pixel_word_i,
  input wire logic [PIX_W-1:0] second_pixel_word_i,
  input wire logic double_input_select_i,
  input wire logic low_rate_select_i,
  input wire logic link_width_select_i,
  input wire logic serial_enable_i,
  input wire logic control_mode_select_i,
  input wire logic command_byte_only_select_i,
  input wire logic uc_on_far_side_i,
  input wire logic uart_rx_i,
  input wire logic rev_rx_i,
  output logic [SYM_CNT*SYM_W-1:0] link_code_o,
  output logic link_code_valid_o,
  output logic uart_tx_o,
  output logic rev_channel_ready_o,
  output logic bypass_active_o,
  output logic pclk_in_range_o,
  output logic [7:0] fwd_byte_o,
  output logic fwd_byte_valid_o,
  output logic [7:0] own_address_o,
  output logic [7:0] peer_address_o
);
  localparam int POR_W = $clog2(REV_START_CYC_P + 1);
  localparam int HOLD_W = $clog2(LINK_CHANGE_CYC_P + 1);
  localparam int BYP_W = $clog2(BYPASS_WAIT_CYC_P + 1);
  localparam int IDLE_W = BAUD_W + IDLE_SHIFT;

  // 8b/10b of one byte with running disparity, returns {new rd, code}
  function automatic logic [SYM_W:0] enc8b10b(input logic [7:0] b, input logic rd);
    logic [5:0] s6;
    logic [3:0] s4;
    logic r;
    s6 = ENC6[b[4:0]];
    s4 = ENC4[b[7:5]];
    r = rd;
    if (r && ($countones(s6) != 3 || s6 == ENC6_FLIP)) s6 = ~s6;
    if ($countones(s6) != 3) r = ~r;
    if (r && ($countones(s4) != 2 || s4 == ENC4_FLIP)) s4 = ~s4;
    if ($countones(s4) != 2) r = ~r;
    return {r, s6, s4};
  endfunction

  // ---------------- Pixel clock domain ----------------
  logic [1:0] prst;
  logic pix_rst_n;
  pix_cfg_s pcfg_m, pcfg;
  logic fcc_level;
  logic phase;
  logic [WIDE_W-1:0] latch_a;
  logic [DATA32_W-1:0] p_data;
  logic p_valid;
  word_t framed;
  logic f_valid;
  logic f_wide;
  logic [15:0] lfsr;
  logic rd;
  logic [PDIV_W-1:0] pdiv;
  word_t scr;
  logic [SYM_CNT*SYM_W-1:0] next_code;
  logic next_rd;

  // Reset release synchronised to the pixel clock
  always_ff @(posedge pixel_clock_in_i or negedge rst_n_i) begin
    if (!rst_n_i) prst <= 2'b00;
    else prst <= {prst[0], 1'b1};
  end
  assign pix_rst_n = prst[1];

  // Select pins and control-channel level cross in through two flip-flops
  always_ff @(posedge pixel_clock_in_i or negedge pix_rst_n) begin
    if (!pix_rst_n) begin
      pcfg_m <= '0;
      pcfg <= '0;
    end else begin
      pcfg_m <= '{double_input_select: double_input_select_i, wide: link_width_select_i, fcc: fcc_level};
      pcfg <= pcfg_m;
    end
  end

  // Input latch; data is synchronous to the pixel clock so it is captured directly
  always_ff @(posedge pixel_clock_in_i or negedge pix_rst_n) begin
    if (!pix_rst_n) begin
      phase <= 1'b0;
      latch_a <= '0;
      p_data <= '0;
      p_valid <= 1'b0;
    end else if (!pcfg.double_input_select) begin
      phase <= 1'b0;
      p_data <= DATA32_W'(first_pixel_word_i);
      p_valid <= 1'b1;
    end else if (!phase) begin
      phase <= 1'b1;
      latch_a <= first_pixel_word_i[WIDE_W-1:0];
      p_valid <= 1'b0;
    end else begin
      phase <= 1'b0;
      p_valid <= 1'b1;
      if (pcfg.wide) p_data <= {second_pixel_word_i[WIDE_W-1:0], latch_a};
      else p_data <= DATA32_W'({second_pixel_word_i[NARROW_W-1:0], latch_a[NARROW_W-1:0]});
    end
  end

  // Serial word framing: data, control-channel bit, parity
  always_ff @(posedge pixel_clock_in_i or negedge pix_rst_n) begin
    if (!pix_rst_n) begin
      framed <= '0;
      f_valid <= 1'b0;
      f_wide <= 1'b0;
    end else begin
      f_valid <= p_valid;
      f_wide <= pcfg.wide;
      if (pcfg.wide) begin
        // 30 data bits, control bit 31st; parity over 31
        framed[DATA32_W-1:0] <= p_data;
        framed[FCC32] <= pcfg.fcc;
        framed[PAR32] <= ^{pcfg.fcc, p_data};
      end else begin
        // 22 data bits, control bit 23rd; parity over 23
        framed <= '0;
        framed[DATA24_W-1:0] <= p_data[DATA24_W-1:0];
        framed[FCC24] <= pcfg.fcc;
        framed[PAR24] <= ^{pcfg.fcc, p_data[DATA24_W-1:0]};
      end
    end
  end

  // scramble, then encode byte by byte with chained disparity
  always_comb begin
    logic [SYM_W:0] e;
    e = '0;
    scr = framed ^ {lfsr, lfsr};
    if (!f_wide) scr[WORD_W-1:PAR24+1] = '0;
    next_rd = rd;
    next_code = '0;
    for (int i = 0; i < SYM_CNT; i++) begin
      if (f_wide || i < SYM_CNT - 1) begin
        e = enc8b10b(scr[i*8 +: 8], next_rd);
        next_rd = e[SYM_W];
        next_code[i*SYM_W +: SYM_W] = e[SYM_W-1:0];
      end
    end
  end

  // Scrambler state and coder output advance once per link word
  always_ff @(posedge pixel_clock_in_i or negedge pix_rst_n) begin
    if (!pix_rst_n) begin
      lfsr <= SCR_SEED;
      rd <= 1'b0;
      link_code_o <= '0;
      link_code_valid_o <= 1'b0;
    end else begin
      link_code_valid_o <= f_valid;
      if (f_valid) begin
        lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        rd <= next_rd;
        link_code_o <= next_code;
      end
    end
  end

  // Divided pixel clock, measured on the control clock
  always_ff @(posedge pixel_clock_in_i or negedge pix_rst_n) begin
    if (!pix_rst_n) pdiv <= '0;
    else pdiv <= pdiv + 1'b1;
  end

  // ---------------- Control clock domain ----------------
  pins_s sync_m, sync_q;
  logic ptog_d, rx_d, ser_en_d;
  logic [POR_W-1:0] por_cnt;
  logic [HOLD_W-1:0] hold_cnt;
  logic [BYP_W-1:0] byp_cnt;
  logic [$clog2(RATE_WIN_CYC)-1:0] win_cnt;
  int edges;
  rx_state_e rx_state;
  pkt_state_e pkt_state;
  logic [BAUD_W-1:0] bit_len, rx_cnt, tx_cnt;
  logic [2:0] rx_bitn;
  logic [3:0] tx_bits;
  logic [7:0] rx_shift;
  logic rx_done;
  logic locked, pkt_self, pkt_write, ack_req, tx_busy, tx_done;
  logic [7:0] pkt_reg, pkt_left;
  logic [IDLE_W-1:0] idle_cnt;
  logic [7:0] regs [REG_CNT];
  logic [7:0] pend [REG_CNT];
  logic [REG_CNT-1:0] pend_mask;
  logic [UART_LAST_BIT:0] tx_shift;
  logic rx_fall;

  // All control pins except command_byte_only_select_i pass two flip-flops before use
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      // Lines idle high; resetting them low would fake a start bit after reset
      sync_m <= '{rx: 1'b1, rev: 1'b1, default: 1'b0};
      sync_q <= '{rx: 1'b1, rev: 1'b1, default: 1'b0};
    end else begin
      sync_m <= '{rx: uart_rx_i, rev: rev_rx_i, mode: control_mode_select_i,
        ser_en: serial_enable_i, far: uc_on_far_side_i, double_input_select: double_input_select_i,
        wide: link_width_select_i, low: low_rate_select_i, ptog: pdiv[PDIV_W-1]};
      sync_q <= sync_m;
    end
  end
  assign rx_fall = rx_d && !sync_q.rx;

  // Reverse-channel availability timers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      por_cnt <= '0;
      hold_cnt <= '0;
      ser_en_d <= 1'b0;
      rev_channel_ready_o <= 1'b0;
    end else begin
      ser_en_d <= sync_q.ser_en;
      if (por_cnt != POR_W'(REV_START_CYC_P)) por_cnt <= por_cnt + 1'b1;
      // mute after link start or stop
      if (sync_q.ser_en != ser_en_d) hold_cnt <= HOLD_W'(LINK_CHANGE_CYC_P);
      else if (hold_cnt != '0) hold_cnt <= hold_cnt - 1'b1;
      rev_channel_ready_o <= por_cnt == POR_W'(REV_START_CYC_P) && hold_cnt == '0
        && sync_q.ser_en == ser_en_d;
    end
  end

  // bypass entry: waits when the host sits at the far end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      byp_cnt <= '0;
      bypass_active_o <= 1'b0;
    end else if (!sync_q.mode) begin
      byp_cnt <= '0;
      bypass_active_o <= 1'b0;
    end else if (!sync_q.far) begin
      bypass_active_o <= 1'b1;
    end else if (byp_cnt != BYP_W'(BYPASS_WAIT_CYC_P)) begin
      byp_cnt <= byp_cnt + 1'b1;
    end else begin
      bypass_active_o <= 1'b1;
    end
  end

  // pixel clock range check over a fixed window
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ptog_d <= 1'b0;
      win_cnt <= '0;
      edges <= 0;
      pclk_in_range_o <= 1'b0;
    end else begin
      ptog_d <= sync_q.ptog;
      win_cnt <= win_cnt + 1'b1;
      if (win_cnt == '1) begin
        edges <= 0;
        pclk_in_range_o <=
          edges * CLK_KHZ * PDIV_EDGE_PIX >= RANGE_KHZ[{sync_q.low, sync_q.double_input_select, sync_q.wide}][0]
          * RATE_WIN_CYC &&
          edges * CLK_KHZ * PDIV_EDGE_PIX <= RANGE_KHZ[{sync_q.low, sync_q.double_input_select, sync_q.wide}][1]
          * RATE_WIN_CYC;
      end else if (sync_q.ptog != ptog_d) begin
        edges <= edges + 1;
      end
    end
  end

  // UART receiver; the sync byte's start bit sets the bit length
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_state <= R_IDLE;
      rx_d <= 1'b1;
      rx_cnt <= '0;
      rx_bitn <= '0;
      rx_shift <= '0;
      rx_done <= 1'b0;
      bit_len <= BAUD_W'(BAUD_MIN_CYC);
    end else begin
      rx_d <= sync_q.rx;
      rx_done <= 1'b0;
      unique case (rx_state)
        R_IDLE: begin
          // commands ignored in bypass; half duplex while answering
          if (rx_fall && !bypass_active_o && !tx_busy) begin
            rx_bitn <= '0;
            rx_cnt <= locked ? BAUD_W'(bit_len + (bit_len >> 1)) : '0;
            rx_state <= locked ? R_BITS : R_BAUD;
          end
        end
        R_BAUD: begin
          rx_cnt <= rx_cnt + 1'b1;
          // accept 9.6 kbps to 1 Mbps bit lengths
          if (sync_q.rx) begin
            rx_state <= (rx_cnt >= BAUD_W'(BAUD_MIN_CYC / 2)) ? R_BITS : R_IDLE;
            bit_len <= rx_cnt;
            rx_cnt <= rx_cnt >> 1;
          end else if (rx_cnt > BAUD_W'(BAUD_MAX_CYC + BAUD_MAX_CYC / 2)) begin
            rx_state <= R_IDLE;
          end
        end
        R_BITS: begin
          if (rx_cnt == '0) begin
            rx_shift <= {sync_q.rx, rx_shift[7:1]};
            rx_cnt <= bit_len;
            rx_bitn <= rx_bitn + 1'b1;
            if (rx_bitn == 3'd7) rx_state <= R_STOP;
          end else begin
            rx_cnt <= rx_cnt - 1'b1;
          end
        end
        R_STOP: begin
          if (rx_cnt == '0) begin
            rx_done <= sync_q.rx;
            rx_state <= R_IDLE;
          end else begin
            rx_cnt <= rx_cnt - 1'b1;
          end
        end
      endcase
    end
  end

  // Packet decode: sync, address, register, count, data
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      locked <= 1'b0;
      pkt_state <= P_ADDR;
      pkt_self <= 1'b0;
      pkt_write <= 1'b0;
      pkt_reg <= '0;
      pkt_left <= '0;
      pend <= '{default: '0};
      pend_mask <= '0;
      ack_req <= 1'b0;
      idle_cnt <= '0;
      fwd_byte_o <= '0;
      fwd_byte_valid_o <= 1'b0;
    end else begin
      ack_req <= 1'b0;
      fwd_byte_valid_o <= 1'b0;
      // a long idle line drops a half-received packet
      if (rx_state == R_IDLE && sync_q.rx && locked) idle_cnt <= idle_cnt + 1'b1;
      else idle_cnt <= '0;
      if (idle_cnt == IDLE_W'({bit_len, IDLE_SHIFT'(0)})) locked <= 1'b0;
      if (bypass_active_o) begin
        locked <= 1'b0;
      end else if (rx_done && !locked) begin
        // only the sync byte opens a packet
        locked <= rx_shift == SYNC_BYTE;
        pkt_state <= P_ADDR;
        pend_mask <= '0;
      end else if (rx_done) begin
        fwd_byte_o <= rx_shift;
        unique case (pkt_state)
          P_ADDR: begin
            // match against the stored own address
            pkt_self <= rx_shift[7:1] == regs[REG_SELF][7:1];
            pkt_write <= !rx_shift[0];
            fwd_byte_valid_o <= rx_shift[7:1] != regs[REG_SELF][7:1];
            pkt_state <= P_REG;
          end
          P_REG: begin
            pkt_reg <= rx_shift;
            // register byte withheld in command-only mode
            fwd_byte_valid_o <= !pkt_self && !command_byte_only_select_i;
            pkt_state <= P_CNT;
          end
          P_CNT: begin
            pkt_left <= rx_shift;
            fwd_byte_valid_o <= !pkt_self;
            if (!pkt_write || rx_shift == '0) locked <= 1'b0;
            pkt_state <= P_DATA;
          end
          P_DATA: begin
            fwd_byte_valid_o <= !pkt_self;
            if (pkt_self && pkt_reg < 8'(REG_CNT)) begin
              pend[pkt_reg[0]] <= rx_shift;
              pend_mask[pkt_reg[0]] <= 1'b1;
            end
            pkt_reg <= pkt_reg + 1'b1;
            pkt_left <= pkt_left - 1'b1;
            if (pkt_left == 8'h01) begin
              locked <= 1'b0;
              ack_req <= pkt_self;
            end
          end
        endcase
      end
    end
  end

  // acknowledge transmitter, at the host's own bit rate
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_busy <= 1'b0;
      tx_done <= 1'b0;
      tx_cnt <= '0;
      tx_bits <= '0;
      tx_shift <= '1;
    end else begin
      tx_done <= 1'b0;
      if (bypass_active_o) begin
        tx_busy <= 1'b0;
        tx_shift <= '1;
      end else if (ack_req) begin
        tx_busy <= 1'b1;
        tx_shift <= {1'b1, ACK_BYTE, 1'b0};
        tx_cnt <= bit_len;
        tx_bits <= '0;
      end else if (tx_busy && tx_cnt != '0) begin
        tx_cnt <= tx_cnt - 1'b1;
      end else if (tx_busy) begin
        tx_cnt <= bit_len;
        tx_shift <= {1'b1, tx_shift[UART_LAST_BIT:1]};
        tx_bits <= tx_bits + 1'b1;
        tx_busy <= tx_bits != 4'(UART_LAST_BIT);
        tx_done <= tx_bits == 4'(UART_LAST_BIT);
      end
    end
  end

  // staged writes land only once the acknowledge has gone out
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      regs[REG_SELF] <= SER_ADDR_DEF;
      regs[REG_PEER] <= DES_ADDR_DEF;
    end else if (tx_done) begin
      for (int i = 0; i < REG_CNT; i++) begin
        if (pend_mask[i]) regs[i] <= pend[i];
      end
    end
  end

  // Line drivers; base answers locally, bypass relays both ways
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      uart_tx_o <= 1'b1;
      fcc_level <= 1'b1;
      own_address_o <= SER_ADDR_DEF;
      peer_address_o <= DES_ADDR_DEF;
    end else begin
      fcc_level <= sync_q.rx;
      if (!bypass_active_o && tx_busy) uart_tx_o <= tx_shift[0];
      else uart_tx_o <= rev_channel_ready_o ? sync_q.rev : 1'b1;
      own_address_o <= regs[REG_SELF];
      peer_address_o <= regs[REG_PEER];
    end
  end

  // ---------------- Checks ----------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_link_toggle;
    sync_q.ser_en != ser_en_d;
  endsequence
  sequence s_ack_sent;
    tx_done ##1 1'b1;
  endsequence

  a_rev_power_up: assert property ($rose(rev_channel_ready_o) |-> $past(por_cnt) == POR_W'(REV_START_CYC_P))
    else $error("reverse channel ready before power-up wait");
  a_rev_link_mute: assert property (s_link_toggle |=> !rev_channel_ready_o [*8])
    else $error("reverse channel not muted after link change");
  a_ack_frame: assert property ($rose(tx_busy) |-> tx_shift == {1'b1, ACK_BYTE, 1'b0})
    else $error("transmitted frame is not the acknowledge");
  a_write_after_ack: assert property ($changed(own_address_o) |-> $past(tx_done, 2))
    else $error("register changed before acknowledge finished");
  a_commit_path: assert property (s_ack_sent |-> ##1 own_address_o == $past(regs[REG_SELF]))
    else $error("committed address not shown");
  a_sync_lock: assert property ($rose(locked) |-> $past(rx_shift) == SYNC_BYTE)
    else $error("packet opened without sync byte");
  a_bypass_quiet: assert property (bypass_active_o |=> !tx_busy && !locked)
    else $error("command handling while in bypass");
  a_bypass_near: assert property ($rose(sync_q.mode) && !sync_q.far |=> bypass_active_o)
    else $error("local bypass not immediate");
  a_bypass_far: assert property ($rose(sync_q.mode) && sync_q.far |=> !bypass_active_o [*8])
    else $error("remote bypass entered without wait");
  a_half_duplex: assert property (!bypass_active_o && tx_busy |=> uart_tx_o == $past(tx_shift[0]))
    else $error("reverse data mixed into acknowledge");
  a_word_parity: assert property (@(posedge pixel_clock_in_i) disable iff (!pix_rst_n)
    f_valid |-> (f_wide ? ^framed : ^framed[PAR24:0]) == 1'b0)
    else $error("link word parity wrong");
  a_double_pair: assert property (@(posedge pixel_clock_in_i) disable iff (!pix_rst_n)
    p_valid && pcfg.double_input_select && $past(pcfg.double_input_select) |=> !p_valid)
    else $error("double mode emitted two words in a row");
  a_code_follows: assert property (@(posedge pixel_clock_in_i) disable iff (!pix_rst_n)
    f_valid |=> link_code_valid_o)
    else $error("framed word not encoded");
endmodule
`default_nettype wire

/* File: verif/host_uart_model.sv */
// Host microcontroller UART model for base-mode packets
`timescale 1ns/1ps
`default_nettype none
module host_uart_model
  import framer_pkg::*;
#(
  parameter int BIT_CYC = 40
) (
  input wire logic clk_i,
  output logic tx_o
);
  // Line idles high from time zero
  initial tx_o = 1'b1;
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_i) tx_o <= f[i];
      repeat (BIT_CYC - 1) @(posedge clk_i);
    end
  endtask
  task automatic packet(input logic [7:0] a, input logic [7:0] r, input logic [7:0] d);
    repeat (16 * BIT_CYC) @(posedge clk_i);
    send(SYNC_BYTE);
    send(a);
    send(r);
    send(8'h01);
    send(d);
  endtask
endmodule
`default_nettype wire

/* File: verif/serializer_input_and_control_channel_tb.sv */
// Bench for pixel framing and control channel timing
`timescale 1ns/1ps
`default_nettype none
module serializer_input_and_control_channel_tb;
  import framer_pkg::*;
  logic clk = 0, pclk = 0, rst_n = 0, double_input_select = 0, sen = 1, mode = 0, far = 0;
  logic rx, tx, cv, rdy, byp, inr;
  logic [PIX_W-1:0] w = 16'h1234;
  logic [39:0] code;
  logic wid = 0, cbo = 0, rev = 1, fbv;
  logic [7:0] own, peer, b, fb;
  int err_count = 0, total_checks = 0, cyc = 0, k, fwd_n = 0;
  // Control clock 25 ns, pixel clock 15 ns
  always #12.5 clk = ~clk;
  always #7.5 pclk = ~pclk;
  host_uart_model host_uart_model_i (.clk_i(clk), .tx_o(rx));
  serializer_input_and_control_channel #(.REV_START_CYC_P(200), .LINK_CHANGE_CYC_P(100),
    .BYPASS_WAIT_CYC_P(150)) serializer_input_and_control_channel_i (.clk_i(clk),
    .rst_n_i(rst_n), .pixel_clock_in_i(pclk), .first_pixel_word_i(w),
    .second_pixel_word_i(~w), .double_input_select_i(double_input_select), .low_rate_select_i(1'b0),
    .link_width_select_i(wid), .serial_enable_i(sen), .control_mode_select_i(mode),
    .command_byte_only_select_i(cbo), .uc_on_far_side_i(far), .uart_rx_i(rx),
    .rev_rx_i(rev), .link_code_o(code), .link_code_valid_o(cv), .uart_tx_o(tx),
    .rev_channel_ready_o(rdy), .bypass_active_o(byp), .pclk_in_range_o(inr),
    .fwd_byte_o(fb), .fwd_byte_valid_o(fbv), .own_address_o(own), .peer_address_o(peer));
  // Forwarded byte pulses, each seen once at the edge after it is raised
  always @(posedge clk) begin
    if (fbv) fwd_n++;
  end
  task automatic check(input logic [39:0] got, input logic [39:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %0h want %0h", $time, got, exp);
    end
  endtask
  // Settle after the edge so outputs are stable
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic t_reset;
    rev <= 0;
    check(own, 8'h80); // own default
    check(peer, 8'h90); // peer default
    wt(150);
    check(rdy, 0); // still starting
    check(tx, 1); // reverse data held off
    wt(70);
    check(rdy, 1); // usable
    check(tx, 0); // reverse data relayed
    @(posedge clk) rev <= 1;
    $display("reset test done");
  endtask
  // A range window ends within 1024 cycles of any select change
  task automatic t_pix(input logic d, input logic wd, input int n, input logic r);
    @(posedge clk) double_input_select <= d;
    wid <= wd;
    wt(1100);
    k = 0;
    repeat (8) @(posedge pclk) #1 k += cv;
    check(k, n); // word rate
    check(code[39:30] == 10'h000, !wd); // fourth symbol only in 32-bit
    check(inr, r); // clock range
    $display("pixel test done");
  endtask
  // The answer may start before the host's last stop bit ends, so watch in parallel
  task automatic t_uart;
    fork
      host_uart_model_i.packet(8'h80, 8'h00, 8'h84);
      begin
        for (k = 0; k < 4000 && tx; k++) wt(1);
        check(tx, 0); // answer before the host gives up
        check(own, 8'h80); // not yet applied
        wt(20);
        for (int i = 0; i < 10; i++) begin
          if (i > 0 && i < 9) b[i-1] = tx;
          wt(40);
        end
      end
    join
    check(b, ACK_BYTE); // answer byte
    check(own, 8'h84); // applied
    $display("uart test done");
  endtask
  task automatic t_fwd;
    @(posedge clk) cbo <= 1;
    fwd_n = 0;
    host_uart_model_i.packet(8'hA0, 8'h05, 8'h3C);
    wt(4);
    check(fwd_n, 3); // register byte dropped
    check(fb, 8'h3C); // data byte passed on
    check(tx, 1); // no answer for a peripheral
    $display("forward test done");
  endtask
  task automatic t_link;
    @(posedge clk) sen <= 0;
    rev <= 0;
    wt(10);
    check(rdy, 0); // muted
    check(tx, 1); // reverse data blocked
    wt(80);
    check(rdy, 0); // still muted
    wt(30);
    check(rdy, 1); // back
    check(tx, 0); // reverse data again
    @(posedge clk) rev <= 1;
    $display("link test done");
  endtask
  task automatic t_byp;
    @(posedge clk) mode <= 1;
    wt(6);
    check(byp, 1); // near host
    @(posedge clk) mode <= 0;
    far <= 1;
    wt(5);
    @(posedge clk) mode <= 1;
    wt(100);
    check(byp, 0); // far host waits
    wt(60);
    check(byp, 1); // far host on
    $display("bypass test done");
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Hang guard well above the expected run length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      report_and_stop();
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1;
    t_reset();
    t_pix(0, 0, 8, 0);
    t_pix(1, 0, 4, 1);
    t_pix(1, 1, 4, 1);
    t_pix(0, 1, 8, 0);
    t_uart();
    t_fwd();
    t_link();
    t_byp();
    report_and_stop();
  end
endmodule
`default_nettype wire
